/* sbt_tap.v */
// Boundary scan test access port for the SRAM, sampled on the system clock
`timescale 1ns/1ps
`include "sbt_consts.vh"
module sbt_tap (
    input  wire                  clk,
    input  wire                  srst,
    input  wire                  tck,
    input  wire                  tms,
    input  wire                  tms_drv,
    input  wire                  tdi,
    input  wire                  tdi_drv,
    input  wire [`SBT_BSR_W-1:0] pad_in,
    output wire                  tdo,
    output wire                  tdo_oe_n,
    output wire                  dq_hiz,
    output wire                  tap_in_reset
);

    // Controller states
    localparam [3:0] ST_RESET    = 4'h0;
    localparam [3:0] ST_IDLE     = 4'h1;
    localparam [3:0] ST_SEL_DR   = 4'h2;
    localparam [3:0] ST_CAP_DR   = 4'h3;
    localparam [3:0] ST_SHIFT_DR = 4'h4;
    localparam [3:0] ST_EXIT1_DR = 4'h5;
    localparam [3:0] ST_PAUSE_DR = 4'h6;
    localparam [3:0] ST_EXIT2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR   = 4'h8;
    localparam [3:0] ST_SEL_IR   = 4'h9;
    localparam [3:0] ST_CAP_IR   = 4'hA;
    localparam [3:0] ST_SHIFT_IR = 4'hB;
    localparam [3:0] ST_EXIT1_IR = 4'hC;
    localparam [3:0] ST_PAUSE_IR = 4'hD;
    localparam [3:0] ST_EXIT2_IR = 4'hE;
    localparam [3:0] ST_UPD_IR   = 4'hF;

    // Data register selection
    localparam [1:0] DR_BYPASS   = 2'h0;
    localparam [1:0] DR_ID       = 2'h1;
    localparam [1:0] DR_BSR      = 2'h2;

    localparam [`SBT_ID_W-1:0] ID_VALUE = {`SBT_ID_REV_VAL, `SBT_ID_CFG_VAL, `SBT_ID_VND_VAL,
                                           `SBT_ID_MFR_VAL, `SBT_ID_START_BIT};

    // Next controller state for a given sampled mode-select
    function [3:0] next_state;
        input [3:0] st;
        input       m;
        begin
            case (st)
                ST_RESET:    next_state = m ? ST_RESET    : ST_IDLE;
                ST_IDLE:     next_state = m ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_DR:   next_state = m ? ST_SEL_IR   : ST_CAP_DR;
                ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: next_state = m ? ST_UPD_DR   : ST_PAUSE_DR;
                ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: next_state = m ? ST_UPD_DR   : ST_SHIFT_DR;
                ST_UPD_DR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_IR:   next_state = m ? ST_RESET    : ST_CAP_IR;
                ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: next_state = m ? ST_UPD_IR   : ST_PAUSE_IR;
                ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: next_state = m ? ST_UPD_IR   : ST_SHIFT_IR;
                default:     next_state = m ? ST_SEL_DR   : ST_IDLE;
            endcase
        end
    endfunction

    // Which data register an instruction routes between serial input and output
    function [1:0] dr_select;
        input [`SBT_IR_W-1:0] ins;
        begin
            if (ins == `SBT_INS_EXTEST) begin
                dr_select = DR_BSR;
            end else if (ins == `SBT_INS_IDCODE) begin
                dr_select = DR_ID;
            end else if (ins == `SBT_INS_SAMPLEZ) begin
                dr_select = DR_BSR;
            end else if (ins == `SBT_INS_SAMPLE) begin
                dr_select = DR_BSR;
            end else begin
                // 011, 110, 111 and the reserved 101 all fall back to bypass
                dr_select = DR_BYPASS;
            end
        end
    endfunction

    // Instructions that float the data pins while they are active
    function floats_dq;
        input [`SBT_IR_W-1:0] ins;
        begin
            floats_dq = (ins == `SBT_INS_EXTEST) || (ins == `SBT_INS_SAMPLEZ);
        end
    endfunction

    // Pad inputs pass two flops before any logic looks at them
    wire [4:0]            ctl_s;
    wire [`SBT_BSR_W-1:0] pad_s;

    sbt_sync #(
        .WIDTH    (5)
    ) u_ctl_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in ({tck, tms, tms_drv, tdi, tdi_drv}),
        .sync_out (ctl_s)
    );

    sbt_sync #(
        .WIDTH    (`SBT_BSR_W)
    ) u_pad_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (pad_in),
        .sync_out (pad_s)
    );

    wire tck_s     = ctl_s[4];
    wire tms_eff   = ctl_s[3] | ~ctl_s[2];
    wire tdi_eff   = ctl_s[1] | ~ctl_s[0];

    reg                   tck_prev_q;
    reg  [3:0]            state_q;
    reg  [3:0]            state_d;
    reg  [2:0]            ones_q;
    reg  [2:0]            ones_d;
    reg  [`SBT_IR_W-1:0]  ir_sh_q;
    reg  [`SBT_IR_W-1:0]  ir_sh_d;
    reg  [`SBT_IR_W-1:0]  ins_q;
    reg  [`SBT_IR_W-1:0]  ins_d;
    reg                   byp_q;
    reg                   byp_d;
    reg  [`SBT_ID_W-1:0]  id_sh_q;
    reg  [`SBT_ID_W-1:0]  id_sh_d;
    reg  [`SBT_BSR_W-1:0] bsr_q;
    reg  [`SBT_BSR_W-1:0] bsr_d;
    reg                   tdo_q;
    reg                   tdo_d;
    reg                   tdo_oe_n_q;
    reg                   tdo_oe_n_d;
    reg                   dq_hiz_q;

    wire tck_rise  = tck_s & ~tck_prev_q;
    wire tck_fall  = ~tck_s & tck_prev_q;
    wire [1:0] sel = dr_select(ins_q);

    always @(posedge clk) begin
        if (srst) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
        end
    end

    // Controller state, advanced only on a rising test clock
    always @* begin
        state_d = state_q;
        ones_d  = ones_q;
        if (tck_rise) begin
            state_d = next_state(state_q, tms_eff);
            if (!tms_eff) begin
                ones_d = 3'h0;
            end else if (ones_q != `SBT_TMS_RESET_CNT) begin
                ones_d = ones_q + 3'h1;
            end
            // Five highs in a row land in reset whatever the path taken
            if (tms_eff && (ones_q == (`SBT_TMS_RESET_CNT - 3'h1))) begin
                state_d = ST_RESET;
            end
        end
    end

    // Power-up reset puts the controller in its reset state, no test reset pin
    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_RESET;
            ones_q  <= 3'h0;
        end else begin
            state_q <= state_d;
            ones_q  <= ones_d;
        end
    end

    // Instruction shifter and active instruction
    always @* begin
        ir_sh_d = ir_sh_q;
        ins_d   = ins_q;
        if (tck_rise) begin
            case (state_q)
                ST_CAP_IR: begin
                    ir_sh_d = `SBT_IR_CAPTURE;
                end
                ST_SHIFT_IR: begin
                    ir_sh_d = {tdi_eff, ir_sh_q[`SBT_IR_W-1:1]};
                end
                ST_UPD_IR: begin
                    // Code 101 is not blocked; it simply acts as bypass
                    ins_d = ir_sh_q;
                end
                default: begin
                    ir_sh_d = ir_sh_q;
                end
            endcase
            // Load on the edge that enters reset, so the data pins stop floating one system clock later
            if (state_d == ST_RESET) begin
                ins_d = `SBT_INS_IDCODE;
            end
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            ir_sh_q <= `SBT_IR_CAPTURE;
            ins_q   <= `SBT_INS_IDCODE;
        end else begin
            ir_sh_q <= ir_sh_d;
            ins_q   <= ins_d;
        end
    end

    // Data registers; the boundary register captures pad levels and shifts in serial data
    always @* begin
        byp_d   = byp_q;
        id_sh_d = id_sh_q;
        bsr_d   = bsr_q;
        if (tck_rise) begin
            case (state_q)
                ST_UPD_IR: begin
                    if (dr_select(ir_sh_q) == DR_BYPASS) begin
                        byp_d = 1'b0;
                    end
                end
                ST_CAP_DR: begin
                    if (sel == DR_BYPASS) begin
                        byp_d = 1'b0;
                    end else if (sel == DR_ID) begin
                        id_sh_d = ID_VALUE;
                    end else begin
                        // No-connect and ground cells capture whatever the pad shows
                        bsr_d = pad_s;
                    end
                end
                ST_SHIFT_DR: begin
                    if (sel == DR_BYPASS) begin
                        byp_d = tdi_eff;
                    end else if (sel == DR_ID) begin
                        id_sh_d = {tdi_eff, id_sh_q[`SBT_ID_W-1:1]};
                    end else begin
                        bsr_d = {tdi_eff, bsr_q[`SBT_BSR_W-1:1]};
                    end
                end
                default: begin
                    byp_d = byp_q;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            byp_q   <= 1'b0;
            id_sh_q <= ID_VALUE;
            bsr_q   <= {`SBT_BSR_W{1'b0}};
        end else begin
            byp_q   <= byp_d;
            id_sh_q <= id_sh_d;
            bsr_q   <= bsr_d;
        end
    end

    // Serial output moves only on a falling test clock, after the shifters settled
    always @* begin
        tdo_d      = tdo_q;
        tdo_oe_n_d = tdo_oe_n_q;
        if (tck_fall) begin
            if (state_q == ST_SHIFT_IR) begin
                tdo_d      = ir_sh_q[0];
                tdo_oe_n_d = 1'b0;
            end else if (state_q == ST_SHIFT_DR) begin
                if (sel == DR_BYPASS) begin
                    tdo_d = byp_q;
                end else if (sel == DR_ID) begin
                    tdo_d = id_sh_q[0];
                end else begin
                    tdo_d = bsr_q[0];
                end
                tdo_oe_n_d = 1'b0;
            end else begin
                tdo_oe_n_d = 1'b1;
            end
        end
        if (state_q == ST_RESET) begin
            tdo_oe_n_d = 1'b1;
        end
    end

    // The system clock lags the pin by the sync depth, so the output moves two to three clocks after the pin falls
    // and misses the 10 ns window whatever the test clock rate
    always @(posedge clk) begin
        if (srst) begin
            tdo_q      <= 1'b0;
            tdo_oe_n_q <= 1'b1;
            dq_hiz_q   <= 1'b0;
        end else begin
            tdo_q      <= tdo_d;
            tdo_oe_n_q <= tdo_oe_n_d;
            dq_hiz_q   <= floats_dq(ins_q);
        end
    end

    assign tdo          = tdo_q;
    assign tdo_oe_n     = tdo_oe_n_q;
    assign dq_hiz       = dq_hiz_q;
    assign tap_in_reset = (state_q == ST_RESET);

endmodule

/* sbt_consts.vh */
// Constants shared by the boundary scan test port of the synchronous SRAM
// How it works
// - Sixteen-state test controller, forced to its reset state at power-up, no test reset pin.
// - Undriven mode-select and serial data inputs behave as logic one.
// - Scan logic never shifts memory contents; it only observes pads or floats outputs.
// - Instruction 3 bits, bypass 1 bit, identification 32 bits, boundary 123 bits.
// - Decode 000 EXTEST, 001 IDCODE, 010 float-sample, 100 SAMPLE; 011/110/111 BYPASS.
// - EXTEST floats data pins and captures all input pins into the boundary register.
// - Float-sample floats data pins and captures all input pins into the boundary register.
// - SAMPLE captures pin states without floating the data pins.
// - IDCODE shifts serial input in behind the identification value.
// - Bypass bit clears when invoked and holds the last shifted-in bit afterwards.
// - Identification: revision 31:28, configuration 27:18, vendor 17:12, maker 11:1, bit0 one.
// - Cells on unconnected or ground positions are don't-care; controller ignores them.
// - Serial output updates after the test clock falls, valid within 10 ns; the code takes two to three system clocks.
`ifndef SBT_CONSTS_VH
`define SBT_CONSTS_VH

// Register widths
`define SBT_IR_W            3
`define SBT_ID_W            32
`define SBT_BSR_W           123

// Instruction codes
`define SBT_INS_EXTEST      3'h0
`define SBT_INS_IDCODE      3'h1
`define SBT_INS_SAMPLEZ     3'h2
`define SBT_INS_BYPASS      3'h3
`define SBT_INS_SAMPLE      3'h4
`define SBT_INS_RESERVED    3'h5

// Value loaded into the instruction shifter on capture
`define SBT_IR_CAPTURE      3'h1

// Identification field positions
`define SBT_ID_REV_MSB      31
`define SBT_ID_REV_LSB      28
`define SBT_ID_CFG_MSB      27
`define SBT_ID_CFG_LSB      18
`define SBT_ID_VND_MSB      17
`define SBT_ID_VND_LSB      12
`define SBT_ID_MFR_MSB      11
`define SBT_ID_MFR_LSB      1

// Identification field values: arbitrary neutral values
`define SBT_ID_REV_VAL      4'h1
`define SBT_ID_CFG_VAL      10'h2A5
`define SBT_ID_VND_VAL      6'h15
`define SBT_ID_MFR_VAL      11'h3C3
`define SBT_ID_START_BIT    1'h1

// Consecutive high mode-select samples that always reach the reset state
`define SBT_TMS_RESET_CNT   3'h5

// Timing
`define SBT_CLK_NS          25
`define SBT_TDO_VALID_NS    10
`define SBT_TDO_VALID_CYC   (((`SBT_TDO_VALID_NS) / (`SBT_CLK_NS)) < 1 ? 1 : ((`SBT_TDO_VALID_NS) / (`SBT_CLK_NS)))

`endif

/* sbt_sync.v */
// Two-flop synchroniser for pad-level inputs
`timescale 1ns/1ps
module sbt_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    // Only the second stage reads the first one
    always @(posedge clk) begin
        if (srst) begin
            meta_q   <= {WIDTH{1'b0}};
            stable_q <= {WIDTH{1'b0}};
        end else begin
            meta_q   <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;

endmodule

/* sbt_tap_assertions.sv */
// Timing and reset checks on the test port pins
`timescale 1ns/1ps
module sbt_tap_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tms_drv,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    input wire logic dq_hiz,
    input wire logic tap_in_reset
);
    logic       tck_q;
    logic [2:0] fcnt_q;
    logic [2:0] rcnt_q;
    logic [2:0] hi_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Ages of the last test clock edges; saturating keeps long idles harmless
    always @(posedge clk) begin
        tck_q <= tck;
        if (srst) begin
            fcnt_q <= 3'h7;
            rcnt_q <= 3'h7;
            hi_q   <= 3'h0;
        end else begin
            fcnt_q <= (tck_q && !tck) ? 3'h0 : fcnt_q + {2'h0, fcnt_q != 3'h7};
            rcnt_q <= (!tck_q && tck) ? 3'h0 : rcnt_q + {2'h0, rcnt_q != 3'h7};
            if (!tck_q && tck)
                hi_q <= (tms || !tms_drv) ? hi_q + {2'h0, hi_q != 3'h7} : 3'h0;
        end
    end
    sequence s_rise_high;
        !tck_q && tck && (tms || !tms_drv);
    endsequence
    sequence s_after_fall;
        !tck && fcnt_q >= 3'h1 && fcnt_q <= 3'h3;
    endsequence
    property p_reset_state;
        $fell(srst) |-> tap_in_reset && tdo_oe_n && !dq_hiz;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("port not idle after reset");
    property p_oe_off_reset;
        tap_in_reset && $past(tap_in_reset) |-> tdo_oe_n;
    endproperty
    a_oe_off_reset: assert property (p_oe_off_reset) else $error("tdo enabled in reset");
    property p_tdo_on_fall;
        $changed(tdo) && !tdo_oe_n |-> s_after_fall;
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off a falling edge");
    property p_oe_on_fall;
        $fell(tdo_oe_n) |-> s_after_fall;
    endproperty
    a_oe_on_fall: assert property (p_oe_on_fall) else $error("tdo enabled off a falling edge");
    property p_state_on_rise;
        $changed(tap_in_reset) |-> rcnt_q >= 3'h1 && rcnt_q <= 3'h3;
    endproperty
    a_state_on_rise: assert property (p_state_on_rise) else $error("state moved off a rising edge");
    property p_hiz_on_rise;
        $changed(dq_hiz) |-> rcnt_q >= 3'h2 && rcnt_q <= 3'h4;
    endproperty
    a_hiz_on_rise: assert property (p_hiz_on_rise) else $error("data float moved off a rising edge");
    property p_five_high;
        s_rise_high ##0 hi_q >= 3'h4 |-> ##[1:6] tap_in_reset;
    endproperty
    a_five_high: assert property (p_five_high) else $error("five high samples did not reset");
    property p_no_hiz_reset;
        tap_in_reset && $past(tap_in_reset, 2) |-> !dq_hiz;
    endproperty
    a_no_hiz_reset: assert property (p_no_hiz_reset) else $error("data pins floated in reset");
endmodule
bind sbt_tap sbt_tap_checker chk_u (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tms_drv(tms_drv), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .dq_hiz(dq_hiz), .tap_in_reset(tap_in_reset));

/* sbt_host_model.sv */
// Behavioural boundary scan host driving the test link
`timescale 1ns/1ps
module sbt_host (
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 200 ns test clock period; the clock stands low between steps
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        q = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        tck <= 1'b0;
    endtask
    // Mode-select bits are applied first bit first
    task automatic walk(input logic [4:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            step(seq[i], 1'b1, q);
    endtask
    // LSB first; the last bit leaves the shift state, then update and idle
    task automatic shift(input logic [127:0] din, input int n, output logic [127:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(5'h01, 2);
    endtask
    task automatic scan_dr(input logic [127:0] din, input int n, output logic [127:0] dout);
        walk(5'h01, 3);
        shift(din, n, dout);
    endtask
    // Callers never pass the reserved code 3'h5
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic [127:0] d;
        walk(5'h03, 4);
        shift({125'h0, code}, 3, d);
        cap = d[2:0];
    endtask
endmodule

/* sbt_tb.sv */
// Self-checking bench for the boundary scan test port
`timescale 1ns/1ps
`include "sbt_consts.vh"
module testbench;
    localparam logic [31:0] ID_EXP = {`SBT_ID_REV_VAL, `SBT_ID_CFG_VAL, `SBT_ID_VND_VAL, `SBT_ID_MFR_VAL, 1'h1};
    // No-connect and ground cells; none is known, so every cell is compared
    localparam logic [122:0] DC_MASK = 123'h0;
    logic         clk, srst, tck, tms, tms_drv, tdi, tdi_drv;
    logic         tdo, tdo_oe_n, dq_hiz, tap_in_reset;
    logic [122:0] pad_in;
    logic [127:0] dout;
    logic [2:0]   cap;
    int           num_errors, check_count, cyc;
    sbt_tap dut_u (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv),
        .pad_in(pad_in), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .dq_hiz(dq_hiz), .tap_in_reset(tap_in_reset));
    sbt_host host_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    always #12.5 clk = ~clk;
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Flags in the order reset state, output enable, data float
    // The float flag settles one clock after the instruction, so wait an edge first
    task automatic flags(input logic [2:0] exp);
        @(posedge clk);
        cmp({125'h0, tap_in_reset, tdo_oe_n, dq_hiz}, {125'h0, exp});
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_power_up;
        flags(3'h6);
        host_u.walk(5'h00, 1);
        flags(3'h2);
    endtask
    task automatic t_idcode;
        host_u.load_ir(`SBT_INS_IDCODE, cap);
        cmp({125'h0, cap}, {125'h0, `SBT_IR_CAPTURE});
        host_u.scan_dr(128'hC3A50F96, 64, dout);
        cmp(dout, {64'h0, 32'hC3A50F96, ID_EXP});
    endtask
    task automatic t_bypass;
        logic [2:0] codes [3] = '{3'h3, 3'h6, 3'h7};
        for (int i = 0; i < 3; i++) begin
            host_u.load_ir(codes[i], cap);
            host_u.scan_dr(128'hB5, 8, dout);
            cmp(dout, 128'h6A);
            flags(3'h2);
        end
    endtask
    task automatic t_boundary;
        logic [2:0]   codes [3] = '{3'h0, 3'h2, 3'h4};
        logic [122:0] pat;
        for (int i = 0; i < 3; i++) begin
            pat = {41{codes[i] ^ 3'h6}};
            pad_in <= pat;
            host_u.load_ir(codes[i], cap);
            flags({2'h1, codes[i] != 3'h4});
            host_u.scan_dr(128'h0, 123, dout);
            cmp(dout & ~{5'h0, DC_MASK}, {5'h0, pat & ~DC_MASK});
        end
    endtask
    // Undriven data in loads 111, so the requested test code turns into bypass
    task automatic t_undriven;
        tdi_drv <= 1'b0;
        host_u.load_ir(`SBT_INS_EXTEST, cap);
        host_u.scan_dr(128'h0, 8, dout);
        cmp(dout, 128'hFE);
        tdi_drv <= 1'b1;
        host_u.load_ir(`SBT_INS_EXTEST, cap);
        flags(3'h3);
        tms_drv <= 1'b0;
        host_u.walk(5'h00, 5);
        flags(3'h6);
        tms_drv <= 1'b1;
        host_u.walk(5'h00, 1);
        host_u.scan_dr(128'h0, 32, dout);
        cmp(dout, {96'h0, ID_EXP});
    endtask
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        tms_drv = 1'b1;
        tdi_drv = 1'b1;
        pad_in = '0;
        num_errors = 0;
        check_count = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_power_up;
        t_idcode;
        t_bypass;
        t_boundary;
        t_undriven;
        give_verdict;
    end
    // About 5100 cycles are needed; the ceiling leaves ample margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict;
        end
    end
endmodule
